// *** cell_fault_delay_config.sv ***
// configuration registers and delay qualification of cell faults
// assumes comparator outputs arrive asynchronously from the analog side
// Function
// R1: voltage delay bit 7 picks microsecond (0) or millisecond (1) units.
// R2: a voltage delay code n from 1 to 31 means n times 100 time units.
// R3: high-cell delay code zero means no delay and unlatched live flags.
// R4: low-cell delay code zero means no delay and unlatched live flags.
// R5: low-cell threshold bit 7 set disables low-cell detection.
// R6: the five-bit low-cell threshold code runs from 0.7 V in 100 mV steps.
// R7: temperature trip bits 3:0 serve the first input, bits 7:4 the second.
// R8: a temperature nibble of zero disables detection on that input.
// R9: software never writes a temperature nibble above 0x0b.
// R10: temperature delay code n means n times 10 ms.
// R11: temperature delay code zero means no delay and unlatched live flags.
// R12: high-cell threshold code runs from 2 V in 50 mV steps; bit 7 disables.
// R13: the series cell count masks results of unused higher cells.
// R14: a fault is flagged only after its condition holds for the whole delay.
// R15: with a nonzero delay a qualified flag stays set until cleared.
`default_nettype none
`include "cell_fault_defs.svh"

module cell_fault_delay_config
    import cell_fault_pkg::*;
#(
    parameter int MS_CYCLES = `MS_TIME_NS / `CLK_PERIOD_NS
) (
    input  wire logic                    clk_sys_i,
    input  wire logic                    rst_n_i,
    input  wire logic [7:0]              reg_addr_i,
    input  wire logic                    reg_wr_i,
    input  wire logic [7:0]              reg_wdata_i,
    input  wire logic                    reg_rd_i,
    output var  logic [7:0]              reg_rdata_o,
    input  wire logic [1:0]              series_cell_count_i,
    input  wire logic                    clear_faults_i,
    input  wire logic [`CELL_COUNT-1:0]  high_cell_cmp_i,
    input  wire logic [`CELL_COUNT-1:0]  low_cell_cmp_i,
    input  wire logic [`TEMP_COUNT-1:0]  temperature_sense_input_i,
    output var  logic [`HIGH_CODE_W-1:0] high_cell_threshold_code_o,
    output var  logic [`LOW_CODE_W-1:0]  low_cell_threshold_code_o,
    output var  logic [`NIBBLE_W-1:0]    temp_trip_first_input_o,
    output var  logic [`NIBBLE_W-1:0]    temp_trip_second_input_o,
    output var  logic [`CELL_COUNT-1:0]  high_cell_flags_o,
    output var  logic [`CELL_COUNT-1:0]  low_cell_flags_o,
    output var  logic [`TEMP_COUNT-1:0]  temp_flags_o
);

    localparam int US_CYCLES = `US_TIME_NS / `CLK_PERIOD_NS;
    localparam int TEMP_MS   = `TEMP_STEP_MS;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic dly_count_t dly_limit(
        input logic [`DLY_CODE_W-1:0] code
    );
        dly_limit = dly_count_t'(code) * dly_count_t'(`DLY_STEP_UNITS);
    endfunction : dly_limit

    function automatic logic [`CELL_COUNT-1:0] cell_mask(
        input cell_count_code_t cnt
    );
        unique case (cnt)
            2'h0: cell_mask = 6'h3f;
            2'h1: cell_mask = 6'h1f;
            2'h2: cell_mask = 6'h0f;
            2'h3: cell_mask = 6'h07;
        endcase
    endfunction : cell_mask

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    cfg_byte_t high_thr_q;
    cfg_byte_t high_dly_q;
    cfg_byte_t low_thr_q;
    cfg_byte_t low_dly_q;
    cfg_byte_t temp_trip_q;
    cfg_byte_t temp_dly_q;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            high_thr_q  <= `CFG_RESET;
            high_dly_q  <= `CFG_RESET;
            low_thr_q   <= `CFG_RESET;
            low_dly_q   <= `CFG_RESET;
            temp_trip_q <= `CFG_RESET;
            temp_dly_q  <= `CFG_RESET;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                `OFS_HIGH_THR:  high_thr_q  <= reg_wdata_i & `HIGH_THR_MASK;
                `OFS_HIGH_DLY:  high_dly_q  <= reg_wdata_i & `DLY_MASK;
                `OFS_LOW_THR:   low_thr_q   <= reg_wdata_i & `LOW_THR_MASK;
                `OFS_LOW_DLY:   low_dly_q   <= reg_wdata_i & `DLY_MASK;
                `OFS_TEMP_TRIP: temp_trip_q <= reg_wdata_i; // R7
                `OFS_TEMP_DLY:  temp_dly_q  <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                `OFS_HIGH_THR:  reg_rdata_o <= high_thr_q;
                `OFS_HIGH_DLY:  reg_rdata_o <= high_dly_q;
                `OFS_LOW_THR:   reg_rdata_o <= low_thr_q;
                `OFS_LOW_DLY:   reg_rdata_o <= low_dly_q;
                `OFS_TEMP_TRIP: reg_rdata_o <= temp_trip_q;
                `OFS_TEMP_DLY:  reg_rdata_o <= temp_dly_q;
                default:        reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // threshold codes to the comparators
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            high_cell_threshold_code_o <= '0;
            low_cell_threshold_code_o  <= '0;
            temp_trip_first_input_o    <= '0;
            temp_trip_second_input_o   <= '0;
        end else begin
            high_cell_threshold_code_o <= high_thr_q[`HIGH_CODE_W-1:0]; // R12
            low_cell_threshold_code_o  <= low_thr_q[`LOW_CODE_W-1:0]; // R6
            temp_trip_first_input_o    <= temp_trip_q[3:0]; // R7
            temp_trip_second_input_o   <= temp_trip_q[7:4]; // R7
        end
    end

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    logic [`CELL_COUNT-1:0] high_s1_q;
    logic [`CELL_COUNT-1:0] high_s2_q;
    logic [`CELL_COUNT-1:0] low_s1_q;
    logic [`CELL_COUNT-1:0] low_s2_q;
    logic [`TEMP_COUNT-1:0] temp_s1_q;
    logic [`TEMP_COUNT-1:0] temp_s2_q;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            high_s1_q <= '0;
            high_s2_q <= '0;
            low_s1_q  <= '0;
            low_s2_q  <= '0;
            temp_s1_q <= '0;
            temp_s2_q <= '0;
        end else begin
            high_s1_q <= high_cell_cmp_i;
            high_s2_q <= high_s1_q;
            low_s1_q  <= low_cell_cmp_i;
            low_s2_q  <= low_s1_q;
            temp_s1_q <= temperature_sense_input_i;
            temp_s2_q <= temp_s1_q;
        end
    end

    // ****************************************************************
    // time base ticks
    // ****************************************************************
    logic [31:0] us_cnt_q;
    logic [31:0] ms_cnt_q;
    logic [7:0]  step_cnt_q;
    logic        us_tick_q;
    logic        ms_tick_q;
    logic        step_tick_q;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            us_cnt_q  <= '0;
            us_tick_q <= 1'b0;
        end else begin
            us_tick_q <= (us_cnt_q == 32'(US_CYCLES - 1));
            us_cnt_q  <= (us_cnt_q == 32'(US_CYCLES - 1)) ? '0
                                                          : us_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ms_cnt_q  <= '0;
            ms_tick_q <= 1'b0;
        end else begin
            ms_tick_q <= (ms_cnt_q == 32'(MS_CYCLES - 1));
            ms_cnt_q  <= (ms_cnt_q == 32'(MS_CYCLES - 1)) ? '0
                                                          : ms_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            step_cnt_q  <= '0;
            step_tick_q <= 1'b0;
        end else begin
            step_tick_q <= ms_tick_q && step_cnt_q == 8'(TEMP_MS - 1); // R10
            if (ms_tick_q) begin
                step_cnt_q <= (step_cnt_q == 8'(TEMP_MS - 1))
                            ? '0 : step_cnt_q + 1'b1;
            end
        end
    end

    // ****************************************************************
    // fault conditions and qualifiers
    // ****************************************************************
    logic [`CELL_COUNT-1:0] mask;
    logic [`CELL_COUNT-1:0] high_cond;
    logic [`CELL_COUNT-1:0] low_cond;
    logic [`TEMP_COUNT-1:0] temp_cond;
    logic                   high_tick;
    logic                   low_tick;
    dly_count_t             high_limit;
    dly_count_t             low_limit;
    dly_count_t             temp_limit;

    always_comb begin
        mask = cell_mask(series_cell_count_i); // R13
        high_cond = high_s2_q & mask
                  & {`CELL_COUNT{~high_thr_q[`DISABLE_BIT]}}; // R12
        low_cond  = low_s2_q & mask
                  & {`CELL_COUNT{~low_thr_q[`DISABLE_BIT]}}; // R5
        temp_cond[0] = temp_s2_q[0] && temp_trip_q[3:0] != 4'h0; // R8
        temp_cond[1] = temp_s2_q[1] && temp_trip_q[7:4] != 4'h0; // R8
        high_tick  = high_dly_q[`TIME_BASE_BIT] ? ms_tick_q : us_tick_q; // R1
        low_tick   = low_dly_q[`TIME_BASE_BIT] ? ms_tick_q : us_tick_q; // R1
        high_limit = dly_limit(high_dly_q[`DLY_CODE_W-1:0]); // R2 R3
        low_limit  = dly_limit(low_dly_q[`DLY_CODE_W-1:0]); // R2 R4
        temp_limit = dly_count_t'(temp_dly_q); // R10 R11
    end

    for (genvar i = 0; i < `CELL_COUNT; i++) begin : g_cell
        fault_qualifier #(.CNT_W(12)) u_high (
            .clk_sys_i (clk_sys_i),
            .rst_n_i   (rst_n_i),
            .cond_i    (high_cond[i]),
            .tick_i    (high_tick),
            .limit_i   (high_limit),
            .clear_i   (clear_faults_i),
            .flag_o    (high_cell_flags_o[i])
        );
        fault_qualifier #(.CNT_W(12)) u_low (
            .clk_sys_i (clk_sys_i),
            .rst_n_i   (rst_n_i),
            .cond_i    (low_cond[i]),
            .tick_i    (low_tick),
            .limit_i   (low_limit),
            .clear_i   (clear_faults_i),
            .flag_o    (low_cell_flags_o[i])
        );
    end

    for (genvar j = 0; j < `TEMP_COUNT; j++) begin : g_temp
        fault_qualifier #(.CNT_W(12)) u_temp (
            .clk_sys_i (clk_sys_i),
            .rst_n_i   (rst_n_i),
            .cond_i    (temp_cond[j]),
            .tick_i    (step_tick_q),
            .limit_i   (temp_limit),
            .clear_i   (clear_faults_i),
            .flag_o    (temp_flags_o[j])
        );
    end

endmodule : cell_fault_delay_config

`default_nettype wire

// *** cell_fault_defs.svh ***
// register offsets, field positions, reset values and timing figures
// assumes a 50 MHz system clock and byte-wide register access
`ifndef CELL_FAULT_DEFS_SVH
`define CELL_FAULT_DEFS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_HIGH_THR    8'h42
`define OFS_HIGH_DLY    8'h43
`define OFS_LOW_THR     8'h44
`define OFS_LOW_DLY     8'h45
`define OFS_TEMP_TRIP   8'h46
`define OFS_TEMP_DLY    8'h47

// ****************************************************************
// field positions and masks
// ****************************************************************
`define DISABLE_BIT     7
`define TIME_BASE_BIT   7
`define HIGH_THR_MASK   8'hbf
`define LOW_THR_MASK    8'h9f
`define DLY_MASK        8'h9f
`define DLY_CODE_W      5
`define HIGH_CODE_W     6
`define LOW_CODE_W      5
`define NIBBLE_W        4
`define CFG_RESET       8'h00

// ****************************************************************
// timing and input counts
// ****************************************************************
`define CLK_PERIOD_NS   20
`define US_TIME_NS      1000
`define MS_TIME_NS      1000000
`define DLY_STEP_UNITS  100
`define TEMP_STEP_MS    10
`define CELL_COUNT      6
`define TEMP_COUNT      2

`endif

// *** cell_fault_pkg.sv ***
// types shared by the fault qualification block
// assumes cell_fault_defs.svh is on the include path
`default_nettype none

package cell_fault_pkg;
    typedef logic [7:0]  cfg_byte_t;
    typedef logic [11:0] dly_count_t;
    typedef logic [1:0]  cell_count_code_t;
endpackage : cell_fault_pkg

`default_nettype wire

// *** fault_qualifier.sv ***
// one fault qualifier: persistence timer and latched flag
// assumes cond_i is already synchronous to clk_sys_i
`default_nettype none

module fault_qualifier #(
    parameter int CNT_W = 12
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_n_i,
    input  wire logic             cond_i,
    input  wire logic             tick_i,
    input  wire logic [CNT_W-1:0] limit_i,
    input  wire logic             clear_i,
    output var  logic             flag_o
);

    logic [CNT_W-1:0] cnt_q;

    // ****************************************************************
    // persistence timer
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
        end else if (!cond_i) begin
            cnt_q <= '0; // R14
        end else if (tick_i && cnt_q < limit_i) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // ****************************************************************
    // flag
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            flag_o <= 1'b0;
        end else if (limit_i == '0) begin
            flag_o <= cond_i;
        end else if (cond_i && cnt_q >= limit_i) begin
            flag_o <= 1'b1; // R14
        end else if (clear_i) begin
            flag_o <= 1'b0; // R15
        end
    end

endmodule : fault_qualifier

`default_nettype wire

// *** cell_fault_delay_config_assertions.sv ***
// checker of register read-back and fault flag timing
// assumes it is bound onto cell_fault_delay_config
`default_nettype none
`include "cell_fault_defs.svh"

module fault_cfg_checker #(
    parameter int MS_CYCLES = 5
) (
    input wire logic                    clk_sys_i,
    input wire logic                    rst_n_i,
    input wire logic [7:0]              reg_addr_i,
    input wire logic                    reg_wr_i,
    input wire logic [7:0]              reg_wdata_i,
    input wire logic                    reg_rd_i,
    input wire logic [7:0]              reg_rdata_o,
    input wire logic [`CELL_COUNT-1:0]  high_cell_cmp_i,
    input wire logic [`CELL_COUNT-1:0]  low_cell_cmp_i,
    input wire logic [`TEMP_COUNT-1:0]  temperature_sense_input_i,
    input wire logic [`HIGH_CODE_W-1:0] high_cell_threshold_code_o,
    input wire logic [`LOW_CODE_W-1:0]  low_cell_threshold_code_o,
    input wire logic [`NIBBLE_W-1:0]    temp_trip_first_input_o,
    input wire logic [`NIBBLE_W-1:0]    temp_trip_second_input_o,
    input wire logic [`CELL_COUNT-1:0]  high_cell_flags_o,
    input wire logic [`CELL_COUNT-1:0]  low_cell_flags_o,
    input wire logic [`TEMP_COUNT-1:0]  temp_flags_o
);
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence wr_to(logic [7:0] a);
        reg_wr_i && reg_addr_i == a;
    endsequence
    sequence rd_of(logic [7:0] a);
        reg_rd_i && reg_addr_i == a;
    endsequence
    rsv_high_a: assert property (rd_of(8'h42) |=> !reg_rdata_o[6])
        else $error("reserved threshold bit read set");
    rsv_dly_a: assert property ((rd_of(8'h43) or rd_of(8'h44)
        or rd_of(8'h45)) |=> reg_rdata_o[6:5] == 2'h0)
        else $error("spare bits set");
    rd_unmapped_a: assert property (reg_rd_i
        && (reg_addr_i < 8'h42 || reg_addr_i > 8'h47)
        |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    high_thr_a: assert property (wr_to(8'h42) |=> ##1
        high_cell_threshold_code_o == $past(reg_wdata_i[5:0], 2))
        else $error("high threshold output wrong");
    low_thr_a: assert property (wr_to(8'h44) |=> ##1
        low_cell_threshold_code_o == $past(reg_wdata_i[4:0], 2))
        else $error("low threshold output wrong");
    trip_first_a: assert property (wr_to(8'h46) |=> ##1
        temp_trip_first_input_o == $past(reg_wdata_i[3:0], 2))
        else $error("first trip nibble wrong");
    trip_second_a: assert property (wr_to(8'h46) |=> ##1
        temp_trip_second_input_o == $past(reg_wdata_i[7:4], 2))
        else $error("second trip nibble wrong");
    high_rise_a: assert property ((high_cell_flags_o
        & ~$past(high_cell_flags_o) & ~$past(high_cell_cmp_i, 3)) == 6'h00)
        else $error("high flag set without condition");
    low_rise_a: assert property ((low_cell_flags_o
        & ~$past(low_cell_flags_o) & ~$past(low_cell_cmp_i, 3)) == 6'h00)
        else $error("low flag set without condition");
    temp_rise_a: assert property ((temp_flags_o & ~$past(temp_flags_o)
        & ~$past(temperature_sense_input_i, 3)) == 2'h0)
        else $error("temp flag set without condition");
endmodule : fault_cfg_checker

bind cell_fault_delay_config fault_cfg_checker #(.MS_CYCLES(MS_CYCLES))
    fault_cfg_checker_i (.clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wr_i,
    .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .high_cell_cmp_i, .low_cell_cmp_i,
    .temperature_sense_input_i, .high_cell_threshold_code_o,
    .low_cell_threshold_code_o, .temp_trip_first_input_o,
    .temp_trip_second_input_o, .high_cell_flags_o, .low_cell_flags_o,
    .temp_flags_o);

`default_nettype wire

// *** cell_fault_delay_config_bench.sv ***
// self-checking bench for cell_fault_delay_config
// assumes the checker file is compiled with it, MS_CYCLES set to 5
`default_nettype none

module cell_fault_delay_config_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // stimulus and checks
    // ****************************************************************
    logic       clk   = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] addr  = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr    = 1'b0;
    logic       rd    = 1'b0;
    logic       clr   = 1'b0;
    logic [1:0] cnt   = 2'h0;
    logic [5:0] hc    = 6'h00;
    logic [5:0] lc    = 6'h00;
    logic [1:0] tc    = 2'h0;
    logic [7:0] rdata;
    logic [5:0] hthr, hfl, lfl;
    logic [4:0] lthr;
    logic [3:0] t1, t2;
    logic [1:0] tfl;
    int         errors = 0;
    int         cmp_count = 0;
    logic [7:0] exp_t [6] = '{8'hbf, 8'h9f, 8'h9f, 8'h9f, 8'hbb, 8'hff};

    always #10 clk = ~clk;

    cell_fault_delay_config #(.MS_CYCLES(5)) cell_fault_delay_config_i (
        .clk_sys_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .series_cell_count_i(cnt), .clear_faults_i(clr),
        .high_cell_cmp_i(hc), .low_cell_cmp_i(lc),
        .temperature_sense_input_i(tc), .high_cell_threshold_code_o(hthr),
        .low_cell_threshold_code_o(lthr), .temp_trip_first_input_o(t1),
        .temp_trip_second_input_o(t2), .high_cell_flags_o(hfl),
        .low_cell_flags_o(lfl), .temp_flags_o(tfl));

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        cyc(1);
        chk(rdata, exp);
    endtask : rd_reg
    task automatic cond(input int k, input logic v);
        @(posedge clk);
        if (k == 0) hc[0] <= v;
        else if (k == 1) lc[0] <= v;
        else tc[0] <= v;
    endtask : cond
    function automatic logic [7:0] flag(input int k);
        return {7'h00, k == 0 ? hfl[0] : k == 1 ? lfl[0] : tfl[0]};
    endfunction : flag
    task automatic qual(input int k, input int early, input int late);
        cond(k, 1'b1);
        cyc(early);
        chk(flag(k), 8'h00);
        cyc(late - early);
        chk(flag(k), 8'h01);
        cond(k, 1'b0);
        cyc(10);
        chk(flag(k), 8'h01);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        cyc(4);
        chk(flag(k), 8'h00);
    endtask : qual

    initial begin
        cyc(40000);
        errors++;
        end_of_test();
    end

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd_reg(8'(8'h42 + i), 8'h00);
            wr_reg(8'(8'h42 + i), i == 4 ? 8'hbb : 8'hff);
            rd_reg(8'(8'h42 + i), exp_t[i]);
        end
        chk({2'h0, hthr}, 8'h3f);
        chk({3'h0, lthr}, 8'h1f);
        chk({t2, t1}, 8'hbb);
        wr_reg(8'h48, 8'h5a);
        rd_reg(8'h48, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            wr_reg(8'(8'h42 + i), i == 4 ? 8'h11 : 8'h00);
        end
        @(posedge clk);
        hc <= 6'h3f;
        lc <= 6'h3f;
        tc <= 2'h3;
        cyc(5);
        chk({2'h0, hfl}, 8'h3f);
        chk({2'h0, lfl}, 8'h3f);
        chk({6'h0, tfl}, 8'h03);
        @(posedge clk);
        cnt <= 2'h2;
        cyc(5);
        chk({lfl, hfl[1:0]}, 8'h3f);
        chk({2'h0, hfl}, 8'h0f);
        @(posedge clk);
        cnt <= 2'h3;
        cyc(5);
        chk({2'h0, lfl}, 8'h07);
        @(posedge clk);
        cnt <= 2'h1;
        cyc(5);
        chk({2'h0, hfl}, 8'h1f);
        @(posedge clk);
        cnt <= 2'h0;
        wr_reg(8'h42, 8'h80);
        wr_reg(8'h44, 8'h80);
        wr_reg(8'h46, 8'h10);
        cyc(5);
        chk({hfl, tfl}, 8'h02);
        chk({2'h0, lfl}, 8'h00);
        wr_reg(8'h46, 8'h01);
        wr_reg(8'h42, 8'h00);
        wr_reg(8'h44, 8'h00);
        cyc(5);
        chk({6'h0, tfl}, 8'h01);
        @(posedge clk);
        hc <= 6'h00;
        lc <= 6'h00;
        tc <= 2'h0;
        cyc(5);
        chk({hfl, tfl}, 8'h00);
        chk({2'h0, lfl}, 8'h00);
        $display("test pass-through done");
        wr_reg(8'h43, 8'h81);
        cond(0, 1'b1);
        cyc(300);
        chk(flag(0), 8'h00);
        cond(0, 1'b0);
        cyc(3);
        chk(flag(0), 8'h00);
        qual(0, 490, 510);
        wr_reg(8'h45, 8'h01);
        qual(1, 4945, 5010);
        wr_reg(8'h45, 8'h9f);
        qual(1, 15490, 15510);
        wr_reg(8'h47, 8'h03);
        qual(2, 98, 160);
        $display("test delays done");
        end_of_test();
    end
endmodule : cell_fault_delay_config_bench

`default_nettype wire
